// >>> verilog/sps_pkg.sv
/*
 * Constants and types shared by the segment profile selector.
 * Assumes a single 250 MHz clock and the shared tables supplied as
 * flat vectors, entry 0 in the lowest bits.
 */
//
// Contract
// - Interrupt option judged at next trigger, once written.
// - Overlap 0 disables blending, 1 enables it.
// - Blended segment keeps speed; next plans from it.
// - Unblended segment stops at zero before next.
// - Blending only for multi-segment, single ignores it.
// - Blending forces dwell time to zero.
// - Blend hands over at the deceleration point.
// - Speed segments: overlap picks rpm or PPS.
// - Accel select picks ramp entry; jump ignores.
// - Decel select picks ramp entry; jump ignores.
// - Run speed select for position segments only.
// - Dwell select picks dwell entry; jump ignores.
// - 32-bit word: planning low, selections high.
// - Multi-segment completion starts the next segment.
package sps_pkg;

	// ---------------------------------------------------------------
	// Control word layout
	// ---------------------------------------------------------------
	localparam int WORD_W = 32;
	localparam int NIB_MODE = 0;
	localparam int NIB_TYPE = 4;
	localparam int NIB_INT = 8;
	localparam int NIB_OVL = 12;
	localparam int NIB_ACC = 16;
	localparam int NIB_DEC = 20;
	localparam int NIB_SPD = 24;
	localparam int NIB_DWL = 28;

	localparam logic [3:0] MODE_SINGLE = 4'h0;
	localparam logic [3:0] MODE_MULTI = 4'h1;
	localparam logic [3:0] MODE_SPEED = 4'h2;
	localparam logic [3:0] MODE_JUMP = 4'h3;
	localparam logic [3:0] OPT_ON = 4'h1;

	// ---------------------------------------------------------------
	// Table shapes
	// ---------------------------------------------------------------
	localparam int ENTRIES = 8;
	localparam int TIME_W = 16;
	localparam int SPEED_W = 32;

	// ---------------------------------------------------------------
	// Timing and reset values
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int DWELL_UNIT_PS = 1000000000;
	localparam int DWELL_UNIT_CYCLES = DWELL_UNIT_PS / CLK_PERIOD_PS;
	localparam int TICK_W = 18;
	localparam logic [WORD_W-1:0] WORD_RST = 32'h00000000;
	localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;
	localparam logic [SPEED_W-1:0] SPEED_RST = 32'h00000000;
	localparam logic [TICK_W-1:0] TICK_RST = 18'h00000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_DECEL,
		ST_DWELL
	} sps_state_type;

endpackage

// >>> verilog/sps_segment_profile_select.sv
/*
 * Segment profile selector: decodes a segment control word, picks the
 * ramp, speed and dwell entries and sequences blend, stop and dwell
 * between segments.
 * Assumes the trajectory loop on the same clock reports the
 * deceleration point and standstill, and that table inputs are stable.
 */
`timescale 1ns/1ps

module sps_segment_profile_select #(
	parameter int P_DWELL_UNIT_CYCLES = sps_pkg::DWELL_UNIT_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [sps_pkg::WORD_W-1:0] i_segment_control_word,
	input wire logic i_word_written,
	input wire logic i_segment_trigger,
	input wire logic i_decel_point,
	input wire logic i_motion_stopped,
	input wire logic [sps_pkg::ENTRIES*sps_pkg::TIME_W-1:0] i_ramp_table,
	input wire logic [sps_pkg::ENTRIES*sps_pkg::SPEED_W-1:0] i_speed_table,
	input wire logic [sps_pkg::ENTRIES*sps_pkg::TIME_W-1:0] i_dwell_table,
	output logic [sps_pkg::TIME_W-1:0] o_accel_time,
	output logic [sps_pkg::TIME_W-1:0] o_decel_time,
	output logic [sps_pkg::SPEED_W-1:0] o_run_speed,
	output logic [sps_pkg::TIME_W-1:0] o_dwell_time,
	output logic o_speed_unit_pps,
	output logic o_blend_enabled,
	output logic o_stop_to_zero,
	output logic o_plan_next,
	output logic o_plan_from_present_speed,
	output logic o_interrupt_taken,
	output logic o_jump_taken,
	output logic o_busy
);
	import sps_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		sps_state_type state;
		logic [WORD_W-1:0] active_word;
		logic [WORD_W-1:0] pending_word;
		logic pending_valid;
		logic queued_trigger;
		logic [TIME_W-1:0] accel;
		logic [TIME_W-1:0] decel;
		logic [SPEED_W-1:0] speed;
		logic [TIME_W-1:0] dwell;
		logic unit_pps;
		logic blend;
		logic stop_zero;
		logic plan_next;
		logic from_speed;
		logic interrupt_taken;
		logic jump_taken;
		logic busy;
		logic [TIME_W-1:0] dwell_cnt;
		logic [TICK_W-1:0] tick_cnt;
	} sps_regs_type;

	localparam logic [TICK_W-1:0] TICK_LAST =
		TICK_W'(P_DWELL_UNIT_CYCLES - 1);

	sps_regs_type s_r;
	sps_regs_type s_nxt;

	// ---------------------------------------------------------------
	// Field helpers
	// ---------------------------------------------------------------
	function automatic logic [3:0] nib(input logic [WORD_W-1:0] w,
		input int pos);
		nib = w[pos +: 4];
	endfunction

	// Values 8..15 have no table entry, so they fall back to entry 0
	function automatic logic [2:0] sel_idx(input logic [3:0] n);
		sel_idx = n[3] ? 3'h0 : n[2:0];
	endfunction

	// Unknown mode codes are run as single-segment positioning
	function automatic logic [3:0] mode_of(input logic [WORD_W-1:0] w);
		logic [3:0] m;
		m = nib(w, NIB_MODE);
		mode_of = (m > MODE_JUMP) ? MODE_SINGLE : m;
	endfunction

	function automatic logic is_pos(input logic [3:0] m);
		is_pos = (m == MODE_SINGLE) || (m == MODE_MULTI);
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic start;
		logic from_speed;
		logic finish;
		logic tick;
		logic [3:0] act_mode;
		logic [3:0] new_mode;
		logic [WORD_W-1:0] w;
		logic [2:0] acc_i;
		logic [2:0] dec_i;
		logic [2:0] spd_i;
		logic [2:0] dwl_i;
		logic new_blend;
		start = 1'b0;
		from_speed = 1'b0;
		finish = 1'b0;
		tick = 1'b0;
		w = s_r.pending_word;
		act_mode = mode_of(s_r.active_word);
		new_mode = mode_of(w);
		acc_i = sel_idx(nib(w, NIB_ACC));
		dec_i = sel_idx(nib(w, NIB_DEC));
		spd_i = sel_idx(nib(w, NIB_SPD));
		dwl_i = sel_idx(nib(w, NIB_DWL));
		// Blending needs a multi-segment word; single ignores overlap
		new_blend = (new_mode == MODE_MULTI) &&
			(nib(w, NIB_OVL) == OPT_ON);
		s_nxt = s_r;
		s_nxt.plan_next = 1'b0;
		s_nxt.interrupt_taken = 1'b0;
		s_nxt.jump_taken = 1'b0;

		// Dwell time base, only running while dwelling
		if (s_r.state == ST_DWELL) begin
			if (s_r.tick_cnt == TICK_LAST) begin
				s_nxt.tick_cnt = TICK_RST;
				tick = 1'b1;
			end else begin
				s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
			end
		end else begin
			s_nxt.tick_cnt = TICK_RST;
		end

		// -----------------------------------------------------------
		// Sequencing
		// -----------------------------------------------------------
		if (s_r.state != ST_IDLE && i_segment_trigger &&
			s_r.pending_valid) begin
			// The option is looked at only now, on a written word
			if (nib(w, NIB_INT) == OPT_ON) begin
				start = 1'b1;
				from_speed = (s_r.state == ST_RUN);
				s_nxt.interrupt_taken = 1'b1;
			end else if (act_mode == MODE_SPEED &&
				s_r.state == ST_RUN) begin
				// A speed segment runs until the next one starts
				start = 1'b1;
				from_speed = 1'b1;
			end else begin
				s_nxt.queued_trigger = 1'b1;
			end
		end
		// A queued trigger must not swallow a decel pulse of the same cycle
		if (!start) begin
			case (s_r.state)
				ST_IDLE: begin
					if (i_segment_trigger && s_r.pending_valid) begin
						start = 1'b1;
					end
				end
				ST_RUN: begin
					if (i_decel_point && is_pos(act_mode)) begin
						if (s_r.blend && s_r.pending_valid &&
							is_pos(new_mode)) begin
							// Hand over without slowing down
							start = 1'b1;
							from_speed = 1'b1;
						end else begin
							s_nxt.stop_zero = 1'b1;
							s_nxt.state = ST_DECEL;
						end
					end
				end
				ST_DECEL: begin
					if (i_motion_stopped) begin
						s_nxt.stop_zero = 1'b0;
						if (s_r.dwell == TIME_RST) begin
							finish = 1'b1;
						end else begin
							s_nxt.dwell_cnt = s_r.dwell;
							s_nxt.state = ST_DWELL;
						end
					end
				end
				ST_DWELL: begin
					if (tick) begin
						s_nxt.dwell_cnt = s_r.dwell_cnt - 1'b1;
						if (s_r.dwell_cnt == 16'h0001) begin
							finish = 1'b1;
						end
					end
				end
				default: begin
					s_nxt.state = ST_IDLE;
				end
			endcase
		end

		// A finished multi-segment chains on, else waits for a trigger
		if (finish) begin
			if (s_r.pending_valid &&
				(act_mode == MODE_MULTI || s_nxt.queued_trigger)) begin
				start = 1'b1;
			end else begin
				s_nxt.state = ST_IDLE;
			end
		end

		// -----------------------------------------------------------
		// Load the next segment
		// -----------------------------------------------------------
		if (start) begin
			s_nxt.pending_valid = 1'b0;
			s_nxt.queued_trigger = 1'b0;
			s_nxt.active_word = w;
			if (new_mode == MODE_JUMP) begin
				// Selections stay as they were for a jump
				s_nxt.jump_taken = 1'b1;
				if (finish) begin
					s_nxt.state = ST_IDLE;
				end
			end else begin
				s_nxt.state = ST_RUN;
				s_nxt.stop_zero = 1'b0;
				s_nxt.plan_next = 1'b1;
				s_nxt.from_speed = from_speed;
				s_nxt.accel = i_ramp_table[{acc_i, 4'h0} +: TIME_W];
				s_nxt.decel = i_ramp_table[{dec_i, 4'h0} +: TIME_W];
				if (is_pos(new_mode)) begin
					s_nxt.speed =
						i_speed_table[{spd_i, 5'h00} +: SPEED_W];
				end
				s_nxt.blend = new_blend;
				if (new_blend) begin
					s_nxt.dwell = TIME_RST;
				end else begin
					s_nxt.dwell =
						i_dwell_table[{dwl_i, 4'h0} +: TIME_W];
				end
				s_nxt.unit_pps = (new_mode == MODE_SPEED) &&
					(nib(w, NIB_OVL) == OPT_ON);
			end
		end

		// A fresh write wins over the consumption in the same cycle
		if (i_word_written) begin
			s_nxt.pending_word = i_segment_control_word;
			s_nxt.pending_valid = 1'b1;
		end
		s_nxt.busy = (s_nxt.state != ST_IDLE);
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			s_r.state <= ST_IDLE;
			s_r.active_word <= WORD_RST;
			s_r.pending_word <= WORD_RST;
			s_r.pending_valid <= 1'b0;
			s_r.queued_trigger <= 1'b0;
			s_r.accel <= TIME_RST;
			s_r.decel <= TIME_RST;
			s_r.speed <= SPEED_RST;
			s_r.dwell <= TIME_RST;
			s_r.unit_pps <= 1'b0;
			s_r.blend <= 1'b0;
			s_r.stop_zero <= 1'b0;
			s_r.plan_next <= 1'b0;
			s_r.from_speed <= 1'b0;
			s_r.interrupt_taken <= 1'b0;
			s_r.jump_taken <= 1'b0;
			s_r.busy <= 1'b0;
			s_r.dwell_cnt <= TIME_RST;
			s_r.tick_cnt <= TICK_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign o_accel_time = s_r.accel;
	assign o_decel_time = s_r.decel;
	assign o_run_speed = s_r.speed;
	assign o_dwell_time = s_r.dwell;
	assign o_speed_unit_pps = s_r.unit_pps;
	assign o_blend_enabled = s_r.blend;
	assign o_stop_to_zero = s_r.stop_zero;
	assign o_plan_next = s_r.plan_next;
	assign o_plan_from_present_speed = s_r.from_speed;
	assign o_interrupt_taken = s_r.interrupt_taken;
	assign o_jump_taken = s_r.jump_taken;
	assign o_busy = s_r.busy;

endmodule

// >>> tb/sps_monitor.sv
/* Port checker for the segment selector.
 * Assumes a bind to sps_segment_profile_select. */
`timescale 1ns/1ps
module sps_monitor (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_segment_trigger,
	input wire logic i_motion_stopped,
	input wire logic [sps_pkg::TIME_W-1:0] o_accel_time,
	input wire logic [sps_pkg::TIME_W-1:0] o_dwell_time,
	input wire logic o_stop_to_zero,
	input wire logic o_blend_enabled,
	input wire logic o_plan_next,
	input wire logic o_plan_from_present_speed,
	input wire logic o_interrupt_taken,
	input wire logic o_jump_taken,
	input wire logic o_busy
);
	import sps_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// Blend flag and dwell are loaded together, so check at the load
	a_blend_no_dwell: assert property (o_plan_next &&
		o_blend_enabled
		|-> o_dwell_time == 16'h0000) else $error("dwell kept");
	a_blend_no_stop: assert property (o_plan_next &&
		o_plan_from_present_speed |-> !o_stop_to_zero)
		else $error("blend stopped");
	a_stop_hold: assert property (o_stop_to_zero &&
		!i_motion_stopped && !i_segment_trigger |=> o_stop_to_zero)
		else $error("stop dropped early");
	a_stop_clears: assert property (o_stop_to_zero &&
		i_motion_stopped |=> !o_stop_to_zero) else $error("stop stuck");
	a_idle_quiet: assert property (!o_busy |->
		!o_stop_to_zero) else $error("stop while idle");
	a_plan_busy: assert property (o_plan_next |-> o_busy)
		else $error("plan while idle");
	a_intr_loads: assert property (o_interrupt_taken |->
		o_plan_next || o_jump_taken) else $error("lone interrupt");
	a_jump_keeps_sel: assert property (o_jump_taken |->
		$stable(o_accel_time) && $stable(o_dwell_time))
		else $error("jump moved selection");
	c_blend: cover property (o_plan_next && o_plan_from_present_speed);
	c_jump: cover property (o_jump_taken);
	c_intr: cover property (o_interrupt_taken);
endmodule
bind sps_segment_profile_select sps_monitor sps_monitor_inst (
	.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_segment_trigger(i_segment_trigger),
	.i_motion_stopped(i_motion_stopped), .o_accel_time(o_accel_time),
	.o_dwell_time(o_dwell_time), .o_stop_to_zero(o_stop_to_zero),
	.o_blend_enabled(o_blend_enabled),
	.o_plan_next(o_plan_next),
	.o_plan_from_present_speed(o_plan_from_present_speed),
	.o_interrupt_taken(o_interrupt_taken), .o_jump_taken(o_jump_taken),
	.o_busy(o_busy));

// >>> tb/sps_motor_model.sv
/* Motor loop stand-in: decel point after a run time, standstill
 * after a stop time. Assumes the selector's clock. */
`timescale 1ns/1ps
module sps_motor_model (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_cruise,
	input wire logic [7:0] i_delay,
	input wire logic i_plan_next,
	input wire logic i_stop_to_zero,
	output logic o_decel_point,
	output logic o_motion_stopped
);
	logic [7:0] run_cnt;
	logic [7:0] stop_cnt;
	// Cruise segments never decelerate; only a trigger ends them
	always @(posedge i_mclk) begin
		o_decel_point <= 1'b0;
		stop_cnt <= 8'h00;
		if (!i_reset_n) begin
			run_cnt <= 8'h00;
			o_motion_stopped <= 1'b1;
		end else if (i_plan_next) begin
			run_cnt <= i_delay;
			o_motion_stopped <= 1'b0;
		end else begin
			if (run_cnt != 8'h00)
				run_cnt <= run_cnt - 8'h01;
			if (run_cnt == 8'h01)
				o_decel_point <= !i_cruise;
			if (i_stop_to_zero && !o_motion_stopped)
				stop_cnt <= stop_cnt + 8'h01;
			if (stop_cnt == i_delay)
				o_motion_stopped <= 1'b1;
		end
	end
endmodule

// >>> tb/sps_segment_profile_select_test.sv
/* Self-checking bench for the segment selector.
 * Assumes package, selector, checker and motor model compiled. */
`timescale 1ns/1ps
module sps_segment_profile_select_test;
	import sps_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] word = 32'h00000000;
	logic wr = 1'b0;
	logic trig = 1'b0;
	logic cruise = 1'b0;
	logic [7:0] dly = 8'h30;
	logic [127:0] ramp, dwl;
	logic [255:0] spd;
	logic decel, stopped, pps, blend, stz, pn, fps, intk, jmp, busy;
	logic [15:0] acc, dec, dwt;
	logic [31:0] run;
	logic saw_stop = 1'b0;
	logic [31:0] seed = 32'hCE90;
	int fail_count = 0;
	int num_checks = 0;
	sps_segment_profile_select #(.P_DWELL_UNIT_CYCLES(4))
		sps_segment_profile_select_inst (.i_mclk(clk),
		.i_reset_n(rst_n), .i_segment_control_word(word),
		.i_word_written(wr), .i_segment_trigger(trig),
		.i_decel_point(decel), .i_motion_stopped(stopped),
		.i_ramp_table(ramp), .i_speed_table(spd), .i_dwell_table(dwl),
		.o_accel_time(acc), .o_decel_time(dec), .o_run_speed(run),
		.o_dwell_time(dwt), .o_speed_unit_pps(pps),
		.o_blend_enabled(blend), .o_stop_to_zero(stz),
		.o_plan_next(pn), .o_plan_from_present_speed(fps),
		.o_interrupt_taken(intk), .o_jump_taken(jmp), .o_busy(busy));
	sps_motor_model sps_motor_model_inst (.i_mclk(clk),
		.i_reset_n(rst_n), .i_cruise(cruise), .i_delay(dly),
		.i_plan_next(pn), .i_stop_to_zero(stz),
		.o_decel_point(decel), .o_motion_stopped(stopped));
	always #2 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Selections above 7 fall back to entry 0
	function automatic int sel(logic [31:0] w, int pos);
		return (w[pos +: 4] > 4'h7) ? 0 : int'(w[pos +: 4]);
	endfunction
	task automatic check(logic [31:0] seen, logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// 0: plan pulse, 1: idle, 2: jump pulse
	task automatic wait_for(int what, int lim);
		int n;
		n = 0;
		#1;
		while (n < lim && !(what == 0 ? pn === 1'b1 :
			what == 1 ? busy === 1'b0 : jmp === 1'b1)) begin
			@(posedge clk);
			#1;
			if (stz === 1'b1) saw_stop = 1'b1;
			n++;
		end
		if (n == lim) check(what, 99);
	endtask
	task automatic go(logic [31:0] w, logic fire);
		@(posedge clk);
		word <= w;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		trig <= fire;
		@(posedge clk);
		trig <= 1'b0;
		if (fire) wait_for(0, 50);
	endtask
	task automatic exp_sel(logic [31:0] w, logic spd_mode);
		check(acc, ramp[sel(w, NIB_ACC)*16 +: 16]);
		check(dec, ramp[sel(w, NIB_DEC)*16 +: 16]);
		check(dwt, dwl[sel(w, NIB_DWL)*16 +: 16]);
		if (!spd_mode) check(run, spd[sel(w, NIB_SPD)*32 +: 32]);
	endtask
	initial begin
		logic [31:0] w, w2;
		logic [79:0] keep;
		for (int k = 0; k < 8; k++) begin
			w = rnd();
			ramp[k*16 +: 16] = w[15:0];
			dwl[k*16 +: 16] = {12'h000, (k == 0) ? 4'h0 : (w[19:16] | 4'h1)};
			spd[k*32 +: 32] = rnd();
		end
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		// Single segments with overlap set, edge and random selections
		for (int i = 0; i < 8; i++) begin
			w = rnd();
			dly <= {3'b000, w[4:0]} + 8'h02;
			w[15:0] = 16'h1000;
			if (i == 0) w[31:16] = 16'h7777;
			if (i == 1) w[31:16] = 16'h8F9A;
			go(w, 1'b1);
			exp_sel(w, 1'b0);
			check(blend, 1'b0);
			check(pps, 1'b0);
			wait_for(1, 500);
		end
		$display("single segments done");
		dly <= 8'h30;
		w2 = {rnd() | 32'h00000000};
		w2[15:0] = 16'h0000;
		for (int b = 0; b < 2; b++) begin
			w = rnd();
			w[31:28] = 4'h5;
			w[15:0] = {3'b000, b[0], 12'h001};
			go(w, 1'b1);
			check(blend, b[0]);
			if (b == 1) check(dwt, 16'h0000);
			if (b == 0) check(dwt, dwl[5*16 +: 16]);
			saw_stop = 1'b0;
			go(w2, 1'b0);
			wait_for(0, 500);
			check(saw_stop, !b[0]);
			check(fps, b[0]);
			check(acc, ramp[sel(w2, NIB_ACC)*16 +: 16]);
			check(dwt, dwl[sel(w2, NIB_DWL)*16 +: 16]);
			wait_for(1, 500);
		end
		$display("blend and stop done");
		go(w2, 1'b1);
		w = rnd();
		w[15:0] = 16'h0100;
		go(w, 1'b0);
		repeat (3) begin
			@(posedge clk);
			#1;
			check(pn, 1'b0);
		end
		go(w, 1'b1);
		check(intk, 1'b1);
		check(fps, 1'b1);
		exp_sel(w, 1'b0);
		wait_for(1, 500);
		$display("interrupt done");
		cruise <= 1'b1;
		for (int u = 0; u < 2; u++) begin
			keep[31:0] = run;
			w = rnd();
			w[15:0] = {3'b000, u[0], 12'h002};
			go(w, 1'b1);
			check(pps, u[0]);
			check(run, keep[31:0]);
			exp_sel(w, 1'b1);
		end
		cruise <= 1'b0;
		go(w2, 1'b1);
		wait_for(1, 500);
		$display("speed segments done");
		keep = {acc, dec, dwt, run};
		go(32'h12340003, 1'b0);
		@(posedge clk);
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
		wait_for(2, 50);
		check(acc, keep[79:64]);
		check(dec, keep[63:48]);
		check(dwt, keep[47:32]);
		wait_for(1, 100);
		// A trigger with no word written must be ignored
		@(posedge clk);
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
		#1;
		check(busy, 1'b0);
		check(pn, 1'b0);
		check(jmp, 1'b0);
		$display("jump done");
		close_out();
	end
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
endmodule
